// ==== bfpd_pkg.sv ====
// package of timing constants and state codes for the fault protection block
// assumes a 25 MHz core clock
package bfpd_pkg;
   // ----------------------------------------
   // clock
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 40;
   localparam int CLK_HZ = 25000000;
   // ----------------------------------------
   // power-up wait, 1 ms least and 2 ms most
   // ----------------------------------------
   localparam int PWRUP_MIN_US = 1000;
   localparam int PWRUP_CYC = (PWRUP_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ----------------------------------------
   // short shutdown bound, about 3 us
   // ----------------------------------------
   localparam int SHORT_SHUT_NS = 3000;
   localparam int SHORT_SHUT_CYC = SHORT_SHUT_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // overcurrent off interval and deglitch blank
   // ----------------------------------------
   localparam int OFF_INTERVAL_NS = 25000;
   localparam int OFF_CYC = OFF_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int BLANK_NS = 2000;
   localparam int BLANK_CYC = BLANK_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // dead interval: ns = 3.7 * kohm, i.e. 37 * kohm / 10
   // ----------------------------------------
   localparam int DT_NUM = 37;
   localparam int DT_DEN = 10;
   localparam int DT_MIN_NS = 30;
   localparam int DT_OPEN_NS = 6000;
   localparam int DT_MIN_CYC = (DT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DT_OPEN_CYC = (DT_OPEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DT_CNT_W = 16;
   localparam int RES_W = 12;
   localparam logic [RES_W-1:0] RES_GROUNDED = 12'h000;
   localparam logic [RES_W-1:0] RES_OPEN = 12'hFFF;
   // ----------------------------------------
   // main states
   // ----------------------------------------
   typedef enum logic [1:0] {
      BFPD_ST_OFF = 2'b00,
      BFPD_ST_PWRUP = 2'b01,
      BFPD_ST_RUN = 2'b10,
      BFPD_ST_LATCH = 2'b11
   } bfpd_state_t;
endpackage

// ==== bfpd_phase_if.sv ====
// interface carrying one phase's requested and delivered gate pair
// used between the top and the dead interval module
`timescale 1ns/10ps
interface bfpd_phase_if;
   logic req_hi;
   logic req_lo;
   logic gate_hi;
   logic gate_lo;
   logic switched;
   modport ctl (output req_hi, output req_lo, input gate_hi, input gate_lo, input switched);
   modport dt (input req_hi, input req_lo, output gate_hi, output gate_lo, output switched);
endinterface

// ==== bfpd_deadtime.sv ====
// one phase of dead interval insertion
// assumes dead cycle count is stable and reset is asynchronous active low
`timescale 1ns/10ps
module bfpd_deadtime #(
   parameter int CNT_W = 16
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // dead interval in cycles
   input wire logic [CNT_W-1:0] dead_cyc_i,
   // phase
   bfpd_phase_if.dt ph
);
   logic gate_hi_q;
   logic gate_lo_q;
   logic [CNT_W-1:0] cnt_q;
   logic sw_q;
   // ----------------------------------------
   // gates wait out the dead count
   // ----------------------------------------
   // gap before complementary turn-on
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         gate_hi_q <= 1'b0;
         gate_lo_q <= 1'b0;
         cnt_q <= '0;
         sw_q <= 1'b0;
      end else begin
         sw_q <= 1'b0;
         if (gate_hi_q && !ph.req_hi) begin
            gate_hi_q <= 1'b0;
            cnt_q <= dead_cyc_i;
            sw_q <= 1'b1;
         end else if (gate_lo_q && !ph.req_lo) begin
            gate_lo_q <= 1'b0;
            cnt_q <= dead_cyc_i;
            sw_q <= 1'b1;
         end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end else if (ph.req_hi && !ph.req_lo && !gate_hi_q && !gate_lo_q) begin
            gate_hi_q <= 1'b1;
            sw_q <= 1'b1;
         end else if (ph.req_lo && !ph.req_hi && !gate_hi_q && !gate_lo_q) begin
            gate_lo_q <= 1'b1;
            sw_q <= 1'b1;
         end
      end
   end
   assign ph.gate_hi = gate_hi_q;
   assign ph.gate_lo = gate_lo_q;
   assign ph.switched = sw_q;
endmodule

// ==== bfpd_protect.sv ====
// top of the protection and gate timing logic of a three phase pre-driver
// assumes comparators outside report short, overcurrent, supply and thermal flags
//
// How it works
// - fault_out_n pulled low while latched or while a short, overcurrent, gate supply or thermal fault stands in run, released otherwise.
// - any MOSFET drop above short_ref_level flags a short.
// - short turns all gates off and latches until sleep or supply loss.
// - overcurrent: high side off, matching low side on for fixed off interval.
// - after the off interval the high side returns; repeats while sense high.
// - drain-source monitor ignored for a blank interval after each switch.
// - dead interval between a turn-off and the complementary turn-on.
// - one setting for all phases; ns equals 3.7 times kilohms.
// - grounded setting gives 30ns, open setting gives about 6us.
// - input undervoltage disables everything and resets logic state.
// - input supply return reruns the full power-up sequence.
// - gate supply low after power-up latches fault, fault output low.
// - over-temperature latches fault; only sleep or supply loss clears.
// - outputs and inputs wait 1ms to 2ms after power-up starts.
// - sleep low disables and ignores inputs; leaving sleep repeats power-up.
// - overcurrent recognised when low side sense exceeds 500mV.
`timescale 1ns/10ps
module bfpd_protect #(
   parameter int PWRUP_CYC = bfpd_pkg::PWRUP_CYC,
   parameter int OFF_CYC = bfpd_pkg::OFF_CYC,
   parameter int BLANK_CYC = bfpd_pkg::BLANK_CYC,
   parameter int NPH = 3
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // supplies and sleep (pins)
   input wire logic sleep_request_n_i,
   input wire logic input_supply_ok_i,
   input wire logic gate_supply_rail_ok_i,
   input wire logic over_temp_i,
   // sensing comparators (pins)
   input wire logic [2*NPH-1:0] drop_above_short_ref_level_i,
   input wire logic low_side_sense_above_threshold_i,
   // dead interval setting resistance in kilohms (pins)
   input wire logic [bfpd_pkg::RES_W-1:0] deadtime_setting_i,
   // commutation requests from commutation logic
   input wire logic [NPH-1:0] req_hi_i,
   input wire logic [NPH-1:0] req_lo_i,
   // gate drive
   output logic [NPH-1:0] gate_hi_o,
   output logic [NPH-1:0] gate_lo_o,
   // open drain fault output
   output logic fault_out_n_o,
   output logic fault_out_n_oe_o
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int SW = 4 + 2 * NPH + 1 + bfpd_pkg::RES_W;
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= {sleep_request_n_i, input_supply_ok_i, gate_supply_rail_ok_i, over_temp_i,
                  drop_above_short_ref_level_i, low_side_sense_above_threshold_i,
                  deadtime_setting_i};
         s2_q <= s1_q;
      end
   end
   logic sleep_n;
   logic vin_ok;
   logic gate_supply_rail_ok;
   logic hot;
   logic [2*NPH-1:0] drop_hi;
   logic oc_sense;
   logic [bfpd_pkg::RES_W-1:0] res_k;
   assign {sleep_n, vin_ok, gate_supply_rail_ok, hot, drop_hi, oc_sense, res_k} = s2_q;

   // ----------------------------------------
   // main state
   // ----------------------------------------
   bfpd_pkg::bfpd_state_t state_q;
   logic [31:0] pu_cnt_q;
   logic [NPH-1:0] sw_ev;
   logic [31:0] blank_q;
   logic short_det;
   assign short_det = (|drop_hi) && (blank_q == '0);
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_q <= bfpd_pkg::BFPD_ST_OFF;
         pu_cnt_q <= '0;
      end else begin
         if (!vin_ok || !sleep_n) begin
            state_q <= bfpd_pkg::BFPD_ST_OFF;
            pu_cnt_q <= '0;
         end else begin
            unique case (state_q)
               bfpd_pkg::BFPD_ST_OFF: begin
                  state_q <= bfpd_pkg::BFPD_ST_PWRUP;
                  pu_cnt_q <= '0;
               end
               bfpd_pkg::BFPD_ST_PWRUP: begin
                  if (pu_cnt_q >= 32'(PWRUP_CYC - 1) && gate_supply_rail_ok) begin
                     state_q <= bfpd_pkg::BFPD_ST_RUN;
                  end else if (pu_cnt_q < 32'(PWRUP_CYC - 1)) begin
                     pu_cnt_q <= pu_cnt_q + 32'h0000_0001;
                  end
               end
               bfpd_pkg::BFPD_ST_RUN: begin
                  if (short_det || !gate_supply_rail_ok || hot) begin
                     state_q <= bfpd_pkg::BFPD_ST_LATCH;
                  end
               end
               bfpd_pkg::BFPD_ST_LATCH: begin
                  state_q <= bfpd_pkg::BFPD_ST_LATCH;
               end
            endcase
         end
      end
   end
   logic run;
   assign run = (state_q == bfpd_pkg::BFPD_ST_RUN);

   // ----------------------------------------
   // deglitch blank after switching
   // ----------------------------------------
   // restart blank on switching
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         blank_q <= '0;
      end else if (|sw_ev) begin
         blank_q <= 32'(BLANK_CYC);
      end else if (blank_q != '0) begin
         blank_q <= blank_q - 32'h0000_0001;
      end
   end

   // ----------------------------------------
   // overcurrent limit cycle
   // ----------------------------------------
   logic [31:0] off_q;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         off_q <= '0;
      end else if (!run) begin
         off_q <= '0;
      end else if (off_q != '0) begin
         off_q <= off_q - 32'h0000_0001;
      end else if (oc_sense && (|gate_hi_o)) begin
         off_q <= 32'(OFF_CYC);
      end
   end
   // high side returns once the off count runs out
   logic limiting;
   assign limiting = (off_q != '0);

   // ----------------------------------------
   // dead interval from setting
   // ----------------------------------------
   logic [31:0] dt_ns;
   logic [bfpd_pkg::DT_CNT_W-1:0] dead_cyc;
   // 3.7 ns per kilohm, all phases
   always_comb begin
      dt_ns = (32'(res_k) * 32'(bfpd_pkg::DT_NUM)) / 32'(bfpd_pkg::DT_DEN);
      if (res_k == bfpd_pkg::RES_GROUNDED) begin
         dead_cyc = bfpd_pkg::DT_CNT_W'(bfpd_pkg::DT_MIN_CYC);
      end else if (res_k == bfpd_pkg::RES_OPEN) begin
         dead_cyc = bfpd_pkg::DT_CNT_W'(bfpd_pkg::DT_OPEN_CYC);
      end else if (dt_ns < 32'(bfpd_pkg::DT_MIN_NS)) begin
         dead_cyc = bfpd_pkg::DT_CNT_W'(bfpd_pkg::DT_MIN_CYC);
      end else begin
         dead_cyc = bfpd_pkg::DT_CNT_W'((dt_ns + 32'(bfpd_pkg::CLK_PERIOD_NS - 1))
                    / 32'(bfpd_pkg::CLK_PERIOD_NS));
      end
   end

   // ----------------------------------------
   // per phase gate timing
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < NPH; g++) begin : g_ph
         bfpd_phase_if ph ();
         // high off, low on while limiting
         // never both gates of one phase
         // outputs dropped at once on short
         assign ph.req_hi = run && !short_det && req_hi_i[g] && !limiting;
         assign ph.req_lo = run && !short_det &&
                            ((req_lo_i[g] && !req_hi_i[g]) || (req_hi_i[g] && limiting));
         bfpd_deadtime #(
            .CNT_W(bfpd_pkg::DT_CNT_W)
         ) u_dt (
            .mclk_i(mclk_i),
            .resetn_i(resetn_i),
            .dead_cyc_i(dead_cyc),
            .ph(ph)
         );
         assign gate_hi_o[g] = ph.gate_hi && run;
         assign gate_lo_o[g] = ph.gate_lo && run;
         assign sw_ev[g] = ph.switched;
      end
   endgenerate

   // ----------------------------------------
   // fault output
   // ----------------------------------------
   logic fault_q;
   always_ff @(posedge mclk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         fault_q <= 1'b0;
      end else begin
         fault_q <= (state_q == bfpd_pkg::BFPD_ST_LATCH) || (run && (short_det || hot ||
                    !gate_supply_rail_ok || oc_sense));
      end
   end
   assign fault_out_n_o = 1'b0;
   assign fault_out_n_oe_o = fault_q;
endmodule

// ==== bfpd_protect_chk.sv ====
// assertions on the ports of the protection block
// assumes a bind to bfpd_protect from the testbench top file
`timescale 1ns/10ps
module bfpd_protect_chk #(
   parameter int NPH = 3
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // pins
   input wire logic sleep_request_n_i,
   input wire logic input_supply_ok_i,
   input wire logic gate_supply_rail_ok_i,
   input wire logic over_temp_i,
   input wire logic [2*NPH-1:0] drop_above_short_ref_level_i,
   input wire logic low_side_sense_above_threshold_i,
   input wire logic [bfpd_pkg::RES_W-1:0] deadtime_setting_i,
   // requests
   input wire logic [NPH-1:0] req_hi_i,
   input wire logic [NPH-1:0] req_lo_i,
   // outputs
   input wire logic [NPH-1:0] gate_hi_o,
   input wire logic [NPH-1:0] gate_lo_o,
   input wire logic fault_out_n_o,
   input wire logic fault_out_n_oe_o
);
   wire logic [2*NPH-1:0] g;
   assign g = {gate_hi_o, gate_lo_o};
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   // ----
   // assertions
   // ----
   no_overlap_a:
      assert property ((gate_hi_o & gate_lo_o) == '0) else $error("both gates of a phase on");
   fault_pin_a:
      assert property (fault_out_n_oe_o |-> !fault_out_n_o) else $error("fault pin not low");
   fault_gates_a:
      assert property (!low_side_sense_above_threshold_i[*4] ##0 fault_out_n_oe_o |-> g == '0)
         else $error("gates on while fault pin low");
   short_off_a:
      assert property (($stable(g) && g != '0)[*8] ##1 ($stable(g) && g != '0)[*4]
         ##1 (|drop_above_short_ref_level_i)[*2] |-> ##[1:75] g == '0)
         else $error("short left gates on");
   oc_limit_a:
      assert property (low_side_sense_above_threshold_i && gate_hi_o != '0
         |-> ##[1:5] (gate_hi_o == '0 && fault_out_n_oe_o)) else $error("high side kept on");
   temp_latch_a:
      assert property (over_temp_i && g != '0 |-> ##[1:6] (g == '0 && fault_out_n_oe_o))
         else $error("over temperature not latched");
   rail_latch_a:
      assert property (!gate_supply_rail_ok_i && g != '0 |-> ##[1:6] (g == '0 && fault_out_n_oe_o))
         else $error("gate supply loss not latched");
   sleep_off_a:
      assert property (!sleep_request_n_i[*6] |-> g == '0 && !fault_out_n_oe_o)
         else $error("active during sleep");
   vin_off_a:
      assert property (!input_supply_ok_i[*6] |-> g == '0 && !fault_out_n_oe_o)
         else $error("active during undervoltage");
   short_c: cover property (|drop_above_short_ref_level_i ##[1:75] fault_out_n_oe_o);
   oc_c: cover property (low_side_sense_above_threshold_i && gate_lo_o != '0);
   sleep_c: cover property ($rose(sleep_request_n_i));
endmodule

// ==== bfpd_bridge_model.sv ====
// model of six bridge MOSFETs and the fault pin pullup
// assumes gate outputs drive the bridge directly
`timescale 1ns/10ps
module bfpd_bridge_model (
   // gates and injected shorts
   input wire logic [2:0] gate_hi_i,
   input wire logic [2:0] gate_lo_i,
   input wire logic [5:0] inj_i,
   input wire logic oe_i,
   input wire logic pin_data_i,
   // drops and pin level
   output logic [5:0] drop_o,
   output logic pin_o
);
   // drop only on a conducting switch
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         drop_o[2*p] = gate_hi_i[p] & inj_i[2*p];
         drop_o[2*p+1] = gate_lo_i[p] & inj_i[2*p+1];
      end
   end
   assign pin_o = oe_i ? pin_data_i : 1'b1;
endmodule

// ==== bfpd_protect_tb.sv ====
// self-checking bench for the protection block
// assumes checker and bridge model compiled first
`timescale 1ns/10ps
module bfpd_protect_tb;
   localparam int PW = 20;
   localparam int OFF = 30;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic sl_n = 1'b1, input_supply = 1'b1, gate_supply_rail = 1'b1, ot = 1'b0, sense = 1'b0;
   logic [5:0] inj = 6'h00;
   logic [5:0] drop;
   logic [11:0] dt = 12'h000;
   logic [2:0] rh = 3'h0, rl = 3'h0, gh, gl;
   logic fn, foe, pin;
   int fail_count = 0, num_checks = 0, k;
   always #20 mclk_i = ~mclk_i;
   bfpd_protect #(.PWRUP_CYC(PW), .OFF_CYC(OFF), .BLANK_CYC(8)) dut (.mclk_i(mclk_i),
      .resetn_i(resetn_i), .sleep_request_n_i(sl_n), .input_supply_ok_i(input_supply),
      .gate_supply_rail_ok_i(gate_supply_rail), .over_temp_i(ot), .drop_above_short_ref_level_i(drop),
      .low_side_sense_above_threshold_i(sense), .deadtime_setting_i(dt), .req_hi_i(rh),
      .req_lo_i(rl), .gate_hi_o(gh), .gate_lo_o(gl), .fault_out_n_o(fn), .fault_out_n_oe_o(foe));
   bfpd_bridge_model bridge (.gate_hi_i(gh), .gate_lo_i(gl), .inj_i(inj), .oe_i(foe),
      .pin_data_i(fn), .drop_o(drop), .pin_o(pin));
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic inr(input int lo, input int hi);
      chk(k >= lo && k <= hi, 1'b1);
   endtask
   task automatic wg(input logic [5:0] e, input int n);
      k = 0;
      while ({gh, gl} !== e && k < n) begin
         cyc(1);
         k++;
      end
      chk({gh, gl}, e);
   endtask
   task automatic report_and_stop;
      if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ----
   // scenarios
   // ----
   task automatic t_dead;
      int e[3] = '{1, 3, 150};
      logic [11:0] s[3] = '{12'h000, 12'h01B, 12'hFFF};
      for (int i = 0; i < 3; i++) begin
         dt <= s[i];
         cyc(4);
         rh <= 3'h0;
         rl <= 3'h1;
         wg(6'h00, 4);
         wg(6'h01, 200);
         inr(e[i] - 1, e[i] + 2);
         rl <= 3'h0;
         rh <= 3'h1;
         wg(6'h00, 4);
         wg(6'h08, 200);
      end
   endtask
   task automatic t_blank;
      dt <= 12'h000;
      cyc(4);
      rh <= 3'h0;
      wg(6'h00, 4);
      rh <= 3'h1;
      wg(6'h08, 4);
      inj <= 6'h01;
      cyc(2);
      inj <= 6'h00;
      cyc(20);
      chk({pin, gh, gl}, 7'h48);
   endtask
   task automatic t_oc;
      sense <= 1'b1;
      wg(6'h01, 20);
      chk(pin, 1'b0);
      wg(6'h08, OFF + 20);
      inr(OFF - 5, OFF + 10);
      wg(6'h01, 20);
      sense <= 1'b0;
      cyc(OFF + 30);
      chk({pin, gh, gl}, 7'h48);
   endtask
   task automatic t_short;
      inj <= 6'h01;
      wg(6'h00, 76);
      inj <= 6'h00;
      cyc(10);
      chk({pin, gh, gl}, 7'h00);
      sl_n <= 1'b0;
      cyc(10);
      chk(pin, 1'b1);
      sl_n <= 1'b1;
      wg(6'h08, PW + 20);
   endtask
   task automatic t_latch;
      for (int i = 0; i < 2; i++) begin
         if (i == 0) ot <= 1'b1;
         else gate_supply_rail <= 1'b0;
         wg(6'h00, 10);
         cyc(3);
         chk(pin, 1'b0);
         ot <= 1'b0;
         gate_supply_rail <= 1'b1;
         cyc(10);
         chk({pin, gh, gl}, 7'h00);
         if (i == 0) input_supply <= 1'b0;
         else sl_n <= 1'b0;
         cyc(10);
         chk(pin, 1'b1);
         input_supply <= 1'b1;
         sl_n <= 1'b1;
         wg(6'h08, PW + 40);
         inr(PW, PW + 15);
      end
   endtask
   initial begin
      cyc(16);
      resetn_i <= 1'b1;
      rh <= 3'h1;
      wg(6'h08, PW + 40);
      inr(PW, PW + 15);
      t_dead();
      t_blank();
      t_oc();
      t_short();
      t_latch();
      report_and_stop();
   end
   initial begin
      #200000;
      fail_count++;
      report_and_stop();
   end
endmodule
bind bfpd_protect bfpd_protect_chk #(.NPH(NPH)) chk_i (.mclk_i, .resetn_i, .sleep_request_n_i,
   .input_supply_ok_i, .gate_supply_rail_ok_i, .over_temp_i, .drop_above_short_ref_level_i,
   .low_side_sense_above_threshold_i, .deadtime_setting_i, .req_hi_i, .req_lo_i, .gate_hi_o,
   .gate_lo_o, .fault_out_n_o, .fault_out_n_oe_o);
